// file: src/psdso_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - per-output mode bit selects normal or delayed
// - hold output on 400-800 ms after trigger
// - normal mode: trigger switches output off immediately
// - hold only if already on; no switch-on
// - supply, timeout, monitor, reset pin start timer
// - restart bit restarts hold timer
// - timer overflow ends delayed switch-off
// - central enable, on-bit, enable bit end hold
// - clearing mode bit ends hold
// - ready state without trigger ends hold
// - power-on reset switches outputs off immediately
// - sleep transition ends delayed switch-off
// - normal config: supply/reset fault clears bits
// - delayed config: listed bits survive the fault
// - per-group overcurrent limit or switch-off select
// - off-state diagnosis currents enable bits
// - bridge freewheel, switch mode, full bridge config
// - push-pull feedback pull-down and threshold config
// - ignition open-load enable, current, time config
// - central enable clear clears all enables
module psdso_top #(
  parameter int HOLD_COUNT = int'(psdso_pkg::HOLD_CYCLES),
  parameter int NUM_SPECIAL = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // trigger sources, asynchronous to clk
  input wire psdso_pkg::psdso_trig_s trig_in,
  input wire logic ready_state,
  input wire logic sleep_request,
  // per-channel protection faults: relay, bridge
  input wire logic [1:0] protect_fault,
  // power stage outputs
  output logic delayed_relay_output,
  output logic delayed_bridge_output,
  output logic [13:0] ls_overcurrent_off,
  output logic [13:0] ls_diag_current_en,
  output logic [11:0] bridge_mode_cfg,
  output logic [11:0] pp_cfg,
  output logic [11:0] ignition_cfg,
  output logic [1:0] hold_active
);

  // synchronise asynchronous inputs
  logic [4:0] trig_s1_q, trig_s2_q;
  logic [1:0] lvl_s1_q, lvl_s2_q;
  logic [1:0] flt_s1_q, flt_s2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trig_s1_q <= 5'h00;
      trig_s2_q <= 5'h00;
      lvl_s1_q <= 2'h0;
      lvl_s2_q <= 2'h0;
      flt_s1_q <= 2'h0;
      flt_s2_q <= 2'h0;
    end else if (clk_en) begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
      lvl_s1_q <= {sleep_request, ready_state};
      lvl_s2_q <= lvl_s1_q;
      flt_s1_q <= protect_fault;
      flt_s2_q <= flt_s1_q;
    end
  end

  psdso_pkg::psdso_trig_s trig;
  logic any_trig, trig_rise, any_trig_q, ready, sleep, supply_rst;
  assign trig = psdso_pkg::psdso_trig_s'(trig_s2_q);
  assign any_trig = |trig_s2_q;
  assign ready = lvl_s2_q[0];
  assign sleep = lvl_s2_q[1];
  // undervoltage or reset pin clear stage bits
  assign supply_rst = trig.supply_under | trig.reset_low;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      any_trig_q <= 1'b0;
    end else if (clk_en) begin
      any_trig_q <= any_trig;
    end
  end
  assign trig_rise = any_trig & ~any_trig_q;

  // bus write strobes; writes complete at the request edge
  logic wr_gen, wr_oe, wr_relay, wr_bmode, wr_bdly, wr_dd, wr_on, wr_ls, wr_pp, wr_ign;
  always_comb begin
    wr_gen = 1'b0;
    wr_oe = 1'b0;
    wr_relay = 1'b0;
    wr_bmode = 1'b0;
    wr_bdly = 1'b0;
    wr_dd = 1'b0;
    wr_on = 1'b0;
    wr_ls = 1'b0;
    wr_pp = 1'b0;
    wr_ign = 1'b0;
    if (avs_write && clk_en) begin
      if (avs_address == psdso_pkg::ADDR_GEN_CMD) wr_gen = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_OE_CFG) wr_oe = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_RELAY_CFG) wr_relay = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_BRIDGE_MODE) wr_bmode = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_BRIDGE_DELAY) wr_bdly = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_DD_CFG) wr_dd = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_ON_CTRL) wr_on = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_LS_CFG) wr_ls = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_PP_CFG) wr_pp = 1'b1;
      else if (avs_address == psdso_pkg::ADDR_IGN_CFG) wr_ign = 1'b1;
    end
  end
  // reads wait one cycle so the registered read data stand when waitrequest drops
  logic rd_done_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_done_q <= 1'b0;
    end else if (clk_en) begin
      rd_done_q <= avs_read & ~rd_done_q;
    end
  end
  assign avs_waitrequest = avs_read & ~rd_done_q;

  logic cen_set, cen_clr, restart;
  assign cen_set = wr_gen & avs_writedata[psdso_pkg::GEN_CENTRAL_SET];
  assign cen_clr = wr_gen & avs_writedata[psdso_pkg::GEN_CENTRAL_CLR];
  assign restart = wr_gen & avs_writedata[psdso_pkg::GEN_HOLD_RESTART];

  // configuration registers
  logic central_en_q;
  logic [1:0] out_en_q, on_ctrl_q, dd_sel_q;
  logic relay_delay_mode_sel_q, relay_openload_cfg_q, relay_overcurrent_cfg_q;
  logic bridge_delay_mode_sel_q;
  logic [11:0] bridge_mode_q, pp_q, ign_q;
  logic [27:0] ls_q;
  logic [1:0] dly_sel, dly_cfg, keep;

  assign dly_sel = {bridge_delay_mode_sel_q, relay_delay_mode_sel_q};
  // delayed mode effective only with serial control; the bridge also needs single-switch mode
  assign dly_cfg[psdso_pkg::BIT_RELAY] = relay_delay_mode_sel_q
    & ~dd_sel_q[psdso_pkg::BIT_RELAY];
  assign dly_cfg[psdso_pkg::BIT_BRIDGE] = bridge_delay_mode_sel_q
    & ~dd_sel_q[psdso_pkg::BIT_BRIDGE]
    & ~bridge_mode_q[psdso_pkg::BRIDGE_FULL_BIT0];
  // bits kept through a supply/reset fault only in delayed config
  assign keep = dly_cfg;

  // central enable and per-output enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      central_en_q <= 1'b0;
      out_en_q <= 2'h0;
    end else if (clk_en) begin
      if (supply_rst && keep == 2'h0) begin
        central_en_q <= 1'b0;
      end else if (cen_clr) begin
        central_en_q <= 1'b0;
      end else if (cen_set) begin
        central_en_q <= 1'b1;
      end
      for (int i = 0; i < NUM_SPECIAL; i++) begin
        if (flt_s2_q[i] || cen_clr || (supply_rst && !keep[i])) begin
          out_en_q[i] <= 1'b0;
        end else if (cen_set || (wr_oe && avs_writedata[i])) begin
          out_en_q[i] <= 1'b1;
        end else if (wr_oe) begin
          out_en_q[i] <= 1'b0;
        end
      end
    end
  end

  // special-output configuration bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relay_delay_mode_sel_q <= 1'b0;
      relay_openload_cfg_q <= 1'b0;
      relay_overcurrent_cfg_q <= 1'b0;
      bridge_delay_mode_sel_q <= 1'b0;
      bridge_mode_q <= 12'h000;
      dd_sel_q <= 2'h0;
    end else if (clk_en) begin
      if (wr_relay) begin
        relay_delay_mode_sel_q <= avs_writedata[psdso_pkg::RELAY_DELAY_BIT];
        relay_openload_cfg_q <= avs_writedata[psdso_pkg::RELAY_OPENLOAD_BIT];
        relay_overcurrent_cfg_q <= avs_writedata[psdso_pkg::RELAY_OVERCURRENT_BIT];
      end else if (supply_rst && !keep[psdso_pkg::BIT_RELAY]) begin
        relay_delay_mode_sel_q <= 1'b0;
        relay_openload_cfg_q <= 1'b0;
        relay_overcurrent_cfg_q <= 1'b0;
      end
      if (wr_bdly) begin
        bridge_delay_mode_sel_q <= avs_writedata[psdso_pkg::BRIDGE_DELAY_BIT];
      end else if (supply_rst && !keep[psdso_pkg::BIT_BRIDGE]) begin
        bridge_delay_mode_sel_q <= 1'b0;
      end
      if (wr_bmode) begin
        bridge_mode_q <= avs_writedata[11:0];
      end else if (supply_rst) begin
        // freewheel and switch mode kept in delayed config
        bridge_mode_q <= keep[psdso_pkg::BIT_BRIDGE]
          ? (bridge_mode_q & psdso_pkg::BRIDGE_KEEP_MASK) : 12'h000;
      end
      if (wr_dd) begin
        dd_sel_q <= avs_writedata[1:0];
      end else if (supply_rst) begin
        dd_sel_q <= 2'h0;
      end
    end
  end

  // serial on-control bits, kept through a fault only in delayed config
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_ctrl_q <= 2'h0;
    end else if (clk_en) begin
      if (wr_on) begin
        on_ctrl_q <= avs_writedata[1:0];
      end else if (supply_rst) begin
        on_ctrl_q <= on_ctrl_q & keep;
      end
    end
  end

  // group configuration for the other stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ls_q <= psdso_pkg::RST_LS_CFG;
      pp_q <= psdso_pkg::RST_PP_CFG;
      ign_q <= psdso_pkg::RST_IGN_CFG;
    end else if (clk_en) begin
      if (wr_ls) ls_q <= avs_writedata[psdso_pkg::LS_WIDTH-1:0];
      if (wr_pp) pp_q <= avs_writedata[psdso_pkg::PP_WIDTH-1:0];
      if (wr_ign) ign_q <= avs_writedata[psdso_pkg::IGN_WIDTH-1:0];
    end
  end

  // per-output delayed switch-off state and hold timers
  psdso_pkg::psdso_state_e state_q [NUM_SPECIAL];
  logic [psdso_pkg::HOLD_CNT_W-1:0] cnt_q [NUM_SPECIAL];
  logic [NUM_SPECIAL-1:0] drive_q, on_req;

  generate
    for (genvar g = 0; g < NUM_SPECIAL; g++) begin : g_ch
      logic end_hold;
      assign on_req[g] = central_en_q & out_en_q[g] & on_ctrl_q[g];
      // leave hold on overflow, switch-off, mode clear, ready, sleep
      assign end_hold = (cnt_q[g] == psdso_pkg::HOLD_CNT_W'(HOLD_COUNT - 1))
        | ~on_req[g]
        | ~dly_sel[g]
        | (ready & ~any_trig)
        | sleep;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          state_q[g] <= psdso_pkg::PSDSO_IDLE;
          cnt_q[g] <= '0;
          drive_q[g] <= 1'b0;
        end else if (clk_en) begin
          case (state_q[g])
            psdso_pkg::PSDSO_IDLE: begin
              if (any_trig && !dly_cfg[g]) begin
                drive_q[g] <= 1'b0;
              end else if (trig_rise && dly_cfg[g] && drive_q[g]) begin
                state_q[g] <= psdso_pkg::PSDSO_HOLD;
                cnt_q[g] <= '0;
              end else if (any_trig) begin
                drive_q[g] <= 1'b0;
              end else begin
                drive_q[g] <= on_req[g];
              end
            end
            psdso_pkg::PSDSO_HOLD: begin
              if (end_hold) begin
                state_q[g] <= psdso_pkg::PSDSO_DONE;
                drive_q[g] <= 1'b0;
              end else if (restart) begin
                cnt_q[g] <= '0;
              end else begin
                cnt_q[g] <= cnt_q[g] + 1'b1;
              end
            end
            psdso_pkg::PSDSO_DONE: begin
              // stay off until triggers have gone
              drive_q[g] <= 1'b0;
              if (!any_trig) state_q[g] <= psdso_pkg::PSDSO_IDLE;
            end
            default: state_q[g] <= psdso_pkg::PSDSO_IDLE;
          endcase
        end
      end
      assign hold_active[g] = (state_q[g] == psdso_pkg::PSDSO_HOLD);
    end
  endgenerate

  assign delayed_relay_output = drive_q[psdso_pkg::BIT_RELAY];
  assign delayed_bridge_output = drive_q[psdso_pkg::BIT_BRIDGE];
  assign ls_overcurrent_off = ls_q[13:0];
  assign ls_diag_current_en = ls_q[27:14];
  assign bridge_mode_cfg = bridge_mode_q;
  assign pp_cfg = pp_q;
  assign ignition_cfg = ign_q;

  // registered read data, captured in the waiting cycle of a read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= psdso_pkg::RST_ZERO;
    end else if (clk_en && avs_read && !rd_done_q) begin
      if (avs_address == psdso_pkg::ADDR_OP_STATUS) avs_readdata <= {31'h0, central_en_q};
      else if (avs_address == psdso_pkg::ADDR_OE_CFG) avs_readdata <= {30'h0, out_en_q};
      else if (avs_address == psdso_pkg::ADDR_RELAY_CFG)
        avs_readdata <= {29'h0, relay_overcurrent_cfg_q, relay_openload_cfg_q,
          relay_delay_mode_sel_q};
      else if (avs_address == psdso_pkg::ADDR_BRIDGE_MODE) avs_readdata <= {20'h0, bridge_mode_q};
      else if (avs_address == psdso_pkg::ADDR_BRIDGE_DELAY)
        avs_readdata <= {31'h0, bridge_delay_mode_sel_q};
      else if (avs_address == psdso_pkg::ADDR_DD_CFG) avs_readdata <= {30'h0, dd_sel_q};
      else if (avs_address == psdso_pkg::ADDR_ON_CTRL) avs_readdata <= {30'h0, on_ctrl_q};
      else if (avs_address == psdso_pkg::ADDR_LS_CFG) avs_readdata <= {4'h0, ls_q};
      else if (avs_address == psdso_pkg::ADDR_PP_CFG) avs_readdata <= {20'h0, pp_q};
      else if (avs_address == psdso_pkg::ADDR_IGN_CFG) avs_readdata <= {20'h0, ign_q};
      else if (avs_address == psdso_pkg::ADDR_DSO_STATUS)
        avs_readdata <= {26'h0, drive_q, hold_active, dly_cfg};
      else avs_readdata <= psdso_pkg::RST_ZERO;
    end
  end

endmodule

// file: src/psdso_pkg.sv
package psdso_pkg;

  // register byte addresses (word aligned)
  localparam logic [5:0] ADDR_GEN_CMD = 6'h00;
  localparam logic [5:0] ADDR_OP_STATUS = 6'h04;
  localparam logic [5:0] ADDR_OE_CFG = 6'h08;
  localparam logic [5:0] ADDR_RELAY_CFG = 6'h0C;
  localparam logic [5:0] ADDR_BRIDGE_MODE = 6'h10;
  localparam logic [5:0] ADDR_BRIDGE_DELAY = 6'h14;
  localparam logic [5:0] ADDR_DD_CFG = 6'h18;
  localparam logic [5:0] ADDR_ON_CTRL = 6'h1C;
  localparam logic [5:0] ADDR_LS_CFG = 6'h20;
  localparam logic [5:0] ADDR_PP_CFG = 6'h24;
  localparam logic [5:0] ADDR_IGN_CFG = 6'h28;
  localparam logic [5:0] ADDR_DSO_STATUS = 6'h2C;

  // general command register bits
  localparam int GEN_CENTRAL_SET = 0;
  localparam int GEN_CENTRAL_CLR = 1;
  localparam int GEN_HOLD_RESTART = 2;
  // output enable / on-control bit positions
  localparam int BIT_RELAY = 0;
  localparam int BIT_BRIDGE = 1;
  // relay configuration register bits
  localparam int RELAY_DELAY_BIT = 0;
  localparam int RELAY_OPENLOAD_BIT = 1;
  localparam int RELAY_OVERCURRENT_BIT = 2;
  // bridge mode register: [3:0] freewheel, [7:4] high/low switch, [11:8] full bridge
  localparam int BRIDGE_FREEWHEEL_LSB = 0;
  localparam int BRIDGE_SWMODE_LSB = 4;
  localparam int BRIDGE_FULL_LSB = 8;
  localparam int BRIDGE_FULL_BIT0 = 8;
  localparam logic [11:0] BRIDGE_KEEP_MASK = 12'h0FF;
  // bridge delay register bit
  localparam int BRIDGE_DELAY_BIT = 0;
  // ignition configuration: [3:0] open-load on enable, [7:4] current, [11:8] time
  localparam int IGN_WIDTH = 12;
  // low side config: [13:0] overcurrent switch-off, [27:14] pull-down / pull current en
  localparam int LS_WIDTH = 28;
  // push pull: [5:0] feedback pull-down, [11:6] threshold
  localparam int PP_WIDTH = 12;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [27:0] RST_LS_CFG = 28'hFFF_C000;
  localparam logic [11:0] RST_PP_CFG = 12'h03F;
  localparam logic [11:0] RST_IGN_CFG = 12'h000;

  // hold time window in ms and clock rate
  localparam int HOLD_MIN_MS = 400;
  localparam int HOLD_MAX_MS = 800;
  localparam int HOLD_NOM_MS = 600;
  localparam longint CLK_HZ = 20_000_000;
  localparam longint HOLD_CYCLES = CLK_HZ / 1000 * HOLD_NOM_MS;
  localparam int HOLD_CNT_W = 24;

  // delayed switch-off per-output state
  typedef enum logic [1:0] {PSDSO_IDLE, PSDSO_HOLD, PSDSO_DONE} psdso_state_e;

  // trigger event group
  typedef struct packed {
    logic supply_under;
    logic supply_over;
    logic link_timeout;
    logic monitor_low;
    logic reset_low;
  } psdso_trig_s;

endpackage

// file: test/psdso_chk.sv
`timescale 1ns/1ps
module psdso_chk #(
  parameter int HOLD_COUNT = 50
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire psdso_pkg::psdso_trig_s trig_in,
  input wire logic ready_state,
  input wire logic sleep_request,
  input wire logic [1:0] protect_fault,
  input wire logic delayed_relay_output,
  input wire logic delayed_bridge_output,
  input wire logic [1:0] hold_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic restart;
  logic [31:0] run_q;
  // restart command seen on the bus
  assign restart = avs_write && avs_address == psdso_pkg::ADDR_GEN_CMD && avs_writedata[2];
  // relay hold length since entry or last restart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= 32'h0;
    end else if (!hold_active[0] || restart) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_q + 32'h1;
    end
  end
  a_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("waitrequest raised outside a read");
  a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read waited more than one cycle");
  a_hold_bounded: assert property (run_q <= HOLD_COUNT + 4)
    else $error("relay hold overran its count");
  a_relay_was_on: assert property ($rose(hold_active[0]) |-> $past(delayed_relay_output))
    else $error("relay hold entered while off");
  a_bridge_was_on: assert property ($rose(hold_active[1]) |-> $past(delayed_bridge_output))
    else $error("bridge hold entered while off");
  a_no_switch_on: assert property (hold_active != 2'b00 && $past(hold_active) != 2'b00 |->
    !$rose(delayed_relay_output) && !$rose(delayed_bridge_output))
    else $error("output switched on during hold");
  a_trig_forces_off: assert property ((trig_in != 5'h00) [*6] ##0
    (hold_active == 2'b00 && $past(hold_active) == 2'b00) |->
    !delayed_relay_output && !delayed_bridge_output)
    else $error("output on under trigger without hold");
  a_fault_drops_relay: assert property (protect_fault[0] [*6] |-> !delayed_relay_output)
    else $error("relay on despite protection fault");
  a_sleep_ends_hold: assert property (sleep_request [*5] |-> hold_active == 2'b00)
    else $error("hold kept under sleep request");
  a_ready_ends_hold: assert property ((ready_state && trig_in == 5'h00) [*5] |->
    hold_active == 2'b00)
    else $error("hold kept in ready state");
  c_relay_hold: cover property ($rose(hold_active[0]));
  c_bridge_hold: cover property ($rose(hold_active[1]));
  c_restart: cover property (restart && hold_active[0]);
endmodule

// file: test/psdso_host.sv
`timescale 1ns/1ps
module psdso_host (
  input wire logic clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // idle bus at time zero
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // one cycle, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    // read data taken at the edge where waitrequest is sampled low
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// file: test/test_power_stage_delayed_switch_off.sv
`timescale 1ns/1ps
module test_power_stage_delayed_switch_off;
  localparam int HC = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  psdso_pkg::psdso_trig_s trig_in = 5'h00;
  logic ready_state = 1'b0;
  logic sleep_request = 1'b0;
  logic [1:0] protect_fault = 2'h0;
  logic delayed_relay_output, delayed_bridge_output;
  logic [13:0] ls_overcurrent_off, ls_diag_current_en;
  logic [11:0] bridge_mode_cfg, pp_cfg, ignition_cfg;
  logic [1:0] hold_active;
  int miscompares = 0;
  int checked = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  psdso_top #(.HOLD_COUNT(HC)) i_dut (.clk, .rstn, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_in, .ready_state,
    .sleep_request, .protect_fault, .delayed_relay_output, .delayed_bridge_output,
    .ls_overcurrent_off, .ls_diag_current_en, .bridge_mode_cfg, .pp_cfg, .ignition_cfg,
    .hold_active);
  psdso_host i_host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  task automatic print_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // outputs as {relay, bridge, hold[1:0]}
  task automatic st(input logic [3:0] e);
    #1;
    cmp({28'h0, delayed_relay_output, delayed_bridge_output, hold_active}, {28'h0, e});
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic trg(input logic [4:0] t);
    @(posedge clk);
    trig_in <= t;
  endtask
  // link-controlled, single switch, then enable and switch on
  task automatic arm(input logic [1:0] mode, input logic [31:0] on);
    wr(psdso_pkg::ADDR_DD_CFG, 32'h0);
    wr(psdso_pkg::ADDR_BRIDGE_MODE, 32'h0);
    wr(psdso_pkg::ADDR_RELAY_CFG, {31'h0, mode[0]});
    wr(psdso_pkg::ADDR_BRIDGE_DELAY, {31'h0, mode[1]});
    wr(psdso_pkg::ADDR_GEN_CMD, 32'h1);
    wr(psdso_pkg::ADDR_ON_CTRL, on);
  endtask
  // hang guard
  initial begin
    cyc(20000);
    miscompares++;
    print_verdict();
  end
  initial begin
    cyc(10);
    rstn <= 1'b1;
    st(4'h0);
    rdc(psdso_pkg::ADDR_LS_CFG, {4'h0, psdso_pkg::RST_LS_CFG});
    rdc(psdso_pkg::ADDR_PP_CFG, {20'h0, psdso_pkg::RST_PP_CFG});
    rdc(6'h30, 32'h0);
    wr(psdso_pkg::ADDR_LS_CFG, 32'h0ABC_5A5A);
    cmp({4'h0, ls_diag_current_en, ls_overcurrent_off}, 32'h0ABC_5A5A);
    wr(psdso_pkg::ADDR_PP_CFG, 32'h0000_0A5C);
    cmp({20'h0, pp_cfg}, 32'h0000_0A5C);
    // frozen clock enable ignores the bus
    clk_en <= 1'b0;
    wr(psdso_pkg::ADDR_PP_CFG, 32'h0000_0123);
    clk_en <= 1'b1;
    cmp({20'h0, pp_cfg}, 32'h0000_0A5C);
    wr(psdso_pkg::ADDR_IGN_CFG, 32'h0000_0C3A);
    cmp({20'h0, ignition_cfg}, 32'h0000_0C3A);
    wr(psdso_pkg::ADDR_BRIDGE_MODE, 32'h0000_05A5);
    cmp({20'h0, bridge_mode_cfg}, 32'h0000_05A5);
    // every trigger source, ended by ready state
    arm(2'h3, 32'h3);
    for (int i = 0; i < 5; i++) begin
      wr(psdso_pkg::ADDR_ON_CTRL, 32'h3);
      trg(5'h01 << i);
      cyc(6);
      st(4'hF);
      rdc(psdso_pkg::ADDR_OE_CFG, 32'h3);
      rdc(psdso_pkg::ADDR_RELAY_CFG, 32'h1);
      rdc(psdso_pkg::ADDR_OP_STATUS, 32'h1);
      trg(5'h00);
      ready_state <= 1'b1;
      cyc(6);
      st(4'hC);
      ready_state <= 1'b0;
    end
    // restart extends, then overflow ends
    trg(5'h04);
    cyc(40);
    wr(psdso_pkg::ADDR_GEN_CMD, 32'h4);
    cyc(30);
    st(4'hF);
    cyc(HC);
    st(4'h0);
    // bridge off at trigger: no hold, no switch-on
    trg(5'h00);
    wr(psdso_pkg::ADDR_ON_CTRL, 32'h1);
    cyc(4);
    trg(5'h04);
    cyc(6);
    st(4'h9);
    wr(psdso_pkg::ADDR_ON_CTRL, 32'h3);
    st(4'h9);
    wr(psdso_pkg::ADDR_ON_CTRL, 32'h0);
    cyc(3);
    st(4'h0);
    // mode bit clear, then sleep
    trg(5'h00);
    wr(psdso_pkg::ADDR_ON_CTRL, 32'h3);
    trg(5'h04);
    cyc(6);
    wr(psdso_pkg::ADDR_RELAY_CFG, 32'h0);
    cyc(3);
    st(4'h6);
    sleep_request <= 1'b1;
    cyc(6);
    st(4'h0);
    sleep_request <= 1'b0;
    // central clear during hold
    trg(5'h00);
    arm(2'h3, 32'h3);
    trg(5'h04);
    cyc(6);
    wr(psdso_pkg::ADDR_GEN_CMD, 32'h2);
    cyc(3);
    st(4'h0);
    rdc(psdso_pkg::ADDR_OE_CFG, 32'h0);
    // normal mode switches off at once
    trg(5'h00);
    arm(2'h0, 32'h3);
    cyc(3);
    trg(5'h10);
    cyc(6);
    st(4'h0);
    rdc(psdso_pkg::ADDR_OE_CFG, 32'h0);
    // protection fault on the relay
    trg(5'h00);
    arm(2'h3, 32'h3);
    protect_fault <= 2'h1;
    cyc(8);
    st(4'h4);
    rdc(psdso_pkg::ADDR_OE_CFG, 32'h2);
    protect_fault <= 2'h0;
    // power-on reset in mid-hold
    arm(2'h3, 32'h3);
    trg(5'h04);
    cyc(6);
    rstn <= 1'b0;
    st(4'h0);
    cyc(10);
    rstn <= 1'b1;
    cyc(2);
    st(4'h0);
    print_verdict();
  end
endmodule
bind psdso_top psdso_chk #(.HOLD_COUNT(HOLD_COUNT)) i_chk (.clk, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .trig_in, .ready_state,
  .sleep_request,
  .protect_fault, .delayed_relay_output, .delayed_bridge_output, .hold_active);
